// *** design/gbc_guard_band_clamp.sv ***
// Guard band clamp: stream datapath, APB control slave and output buffering.

// ==========================================================
// Elastic stage with a registered ready, two entries deep
module gbc_skid #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         i_valid,
	input  wire logic         i_stop,
	output logic              i_ready,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	input  wire logic         o_ready,
	output logic [W-1:0]      o_data
);
	logic         k_valid;
	logic [W-1:0] k_data;

	wire       push     = i_valid && i_ready;
	wire       pop      = o_valid && o_ready;
	wire [1:0] cnt      = {1'b0, o_valid} + {1'b0, k_valid};
	wire [1:0] next_cnt = 2'(cnt + {1'b0, push} - {1'b0, pop});

	// Ready is a flop, so the second entry absorbs the beat taken before it falls
	always_ff @(posedge clk) begin
		if (rst) begin
			i_ready <= 1'b0;
			o_valid <= 1'b0;
			k_valid <= 1'b0;
			o_data  <= '0;
			k_data  <= '0;
		end else begin
			i_ready <= (next_cnt < 2'h2) && !i_stop;
			if (pop) begin
				if (k_valid) begin
					o_data  <= k_data;
					k_valid <= 1'b0;
				end else begin
					o_valid <= push;
					o_data  <= i_data;
				end
			end else if (push) begin
				if (!o_valid) begin
					o_valid <= 1'b1;
					o_data  <= i_data;
				end else begin
					k_valid <= 1'b1;
					k_data  <= i_data;
				end
			end
		end
	end
endmodule

// Behaviour
// - Sample above upper limit becomes upper limit
// - Sample below lower limit becomes lower limit
// - Own limit pair per plane, plane zero lowest
// - Signed input gains half range before clamping
// - Signed output loses half range after clamping
// - Limits are always unsigned
// - Signed input and output never both chosen
// - Sample width parameter 4 to 16, default 8
// - Plane count parameter 1 to 3, default 2
// - Pixels per beat 1, 2, 4 or 8
// - Planes in parallel or in sequence
// - Run bit resets clear, else always set
// - Limits are parameters, reset values, writable
// - User packets dropped, passed or assumed absent
// - Optional extra pipeline stage, same results
// - Control reads back the run bit, limit registers the low sample-width bits last written
// - Reduced readback hides limits, keeps control
// - Software may change limits while running
// - Clearing run bit halts after current packet
// - Status one inside a frame, zero between
module gbc_guard_band_clamp #(
	parameter int          BPS              = 8,
	parameter int          PLANES           = 2,
	parameter int          PIX              = 1,
	parameter bit          PARALLEL         = 1'b1,
	parameter bit          SIGNED_IN        = 1'b0,
	parameter bit          SIGNED_OUT       = 1'b0,
	parameter bit          RUNTIME          = 1'b1,
	parameter bit          EXTRA_PIPE       = 1'b0,
	parameter bit          REDUCED_READBACK = 1'b0,
	parameter int          USER_MODE        = gbc_pkg::GBC_USER_PASS,
	parameter int          ADDR_W           = 8,
	parameter logic [63:0] LOWER_INIT       = 64'h0000000000000000,
	parameter logic [63:0] UPPER_INIT       = 64'h00ff00ff00ff00ff,
	localparam int         LANES            = PIX * (PARALLEL ? PLANES : 1),
	localparam int         DW               = LANES * BPS
) (
	input  wire logic              mclk,
	input  wire logic              srst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic [DW-1:0]     in_data,
	input  wire logic              in_sop,
	input  wire logic              in_eop,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output logic [DW-1:0]          out_data,
	output logic                   out_sop,
	output logic                   out_eop
);
	localparam int  LW      = gbc_pkg::GBC_LIM_W;
	localparam int  NP      = gbc_pkg::GBC_MAX_PLANES;
	localparam int  IDX_TOP = gbc_pkg::GBC_ADDR_LSB + gbc_pkg::GBC_IDX_W;
	localparam bit  GO_RST  = !RUNTIME;
	localparam logic [1:0] LAST_PLANE = 2'(PLANES - 1);

	// ==========================================================
	// Elaboration checks
	if (BPS < 4 || BPS > 16) begin : g_chk_bps
		$error("Sample width must be 4 to 16");
	end
	if (PLANES < 1 || PLANES > 3) begin : g_chk_planes
		$error("Plane count must be 1 to 3");
	end
	if (PIX != 1 && PIX != 2 && PIX != 4 && PIX != 8) begin : g_chk_pix
		$error("Pixels per beat must be 1, 2, 4 or 8");
	end
	if (SIGNED_IN && SIGNED_OUT) begin : g_chk_sign
		$error("Signed input and signed output are exclusive");
	end
	if (USER_MODE < gbc_pkg::GBC_USER_NONE || USER_MODE > gbc_pkg::GBC_USER_PASS) begin : g_chk_um
		$error("Unknown user packet mode");
	end
	if (ADDR_W < IDX_TOP + 1 || ADDR_W > 32) begin : g_chk_addr
		$error("Address width out of range");
	end
	for (genvar p = 0; p < NP; p++) begin : g_chk_lim
		if ((LOWER_INIT[p*LW +: LW] >> BPS) != 0 || (UPPER_INIT[p*LW +: LW] >> BPS) != 0) begin : g_e
			$error("Limit exceeds sample range");
		end
	end

	// ==========================================================
	// Control state
	logic                 go;
	logic [BPS-1:0]       lo_lim [NP];
	logic [BPS-1:0]       hi_lim [NP];
	gbc_pkg::gbc_state_t  state;
	gbc_pkg::gbc_state_t  next_state;
	logic [1:0]           plane_cnt;
	logic                 video_beat;
	logic                 drop_beat;

	wire busy = (state == gbc_pkg::GBC_ST_VIDEO);

	// ==========================================================
	// APB decode
	wire [3:0] reg_idx    = paddr[IDX_TOP-1:gbc_pkg::GBC_ADDR_LSB];
	wire       aligned    = (paddr[gbc_pkg::GBC_ADDR_LSB-1:0] == '0);
	wire       upper_zero = (paddr[ADDR_W-1:IDX_TOP] == '0);
	wire       reg_hit    = aligned && upper_zero && (reg_idx <= gbc_pkg::GBC_IDX_LAST);
	wire       lim_hit    = reg_hit && (reg_idx >= gbc_pkg::GBC_IDX_LIM_BASE);
	wire [3:0] lim_off    = 4'(reg_idx - gbc_pkg::GBC_IDX_LIM_BASE);
	wire [1:0] lim_plane  = lim_off[2:1];
	wire       lim_upper  = lim_off[0];
	wire       apb_access = psel && penable && !pready;
	wire       apb_done   = psel && penable && pready;
	wire       wr_en      = apb_done && pwrite && reg_hit && RUNTIME;
	wire       ctrl_wr    = wr_en && (reg_idx == gbc_pkg::GBC_IDX_CTRL);
	wire       lim_wr     = wr_en && lim_hit;
	wire       next_go    = ctrl_wr ? pwdata[gbc_pkg::GBC_GO_BIT] : go;

	wire [BPS-1:0] lim_val  = lim_upper ? hi_lim[lim_plane] : lo_lim[lim_plane];
	// Hiding the limits saves the wide read mux
	wire [31:0]    lim_word = REDUCED_READBACK ? 32'h0 : 32'(lim_val);
	wire [31:0]    ctl_word = 32'(go) << gbc_pkg::GBC_GO_BIT;
	wire [31:0]    sta_word = 32'(busy) << gbc_pkg::GBC_STAT_BIT;
	wire [31:0]    rd_word  = (reg_idx == gbc_pkg::GBC_IDX_CTRL)   ? ctl_word :
	                          (reg_idx == gbc_pkg::GBC_IDX_STATUS) ? sta_word :
	                          lim_hit ? lim_word : 32'h0;

	// ==========================================================
	// APB answer, one cycle into the access phase
	always_ff @(posedge mclk) begin
		if (srst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_access;
			prdata  <= (apb_access && !pwrite && reg_hit) ? rd_word : 32'h0;
			pslverr <= apb_access && !reg_hit;
		end
	end

	// ==========================================================
	// Run bit and limits
	always_ff @(posedge mclk) begin
		if (srst) begin
			go <= GO_RST;
		end else begin
			go <= next_go;
		end
	end

	always_ff @(posedge mclk) begin
		for (int p = 0; p < NP; p++) begin
			if (srst) begin
				lo_lim[p] <= LOWER_INIT[p*LW +: BPS];
				hi_lim[p] <= UPPER_INIT[p*LW +: BPS];
			end else if (lim_wr && lim_plane == 2'(p)) begin
				if (lim_upper) begin
					hi_lim[p] <= pwdata[BPS-1:0];
				end else begin
					lo_lim[p] <= pwdata[BPS-1:0];
				end
			end
		end
	end

	// ==========================================================
	// Packet tracking
	wire       in_take   = in_valid && in_ready;
	wire [3:0] hdr_type  = in_data[gbc_pkg::GBC_TYPE_W-1:0];
	wire       hdr_video = (hdr_type == gbc_pkg::GBC_TYPE_VIDEO);
	wire       hdr_ctrl  = (hdr_type == gbc_pkg::GBC_TYPE_CTRL);
	wire       hdr_user  = !hdr_video && !hdr_ctrl;
	// With no user packets promised, one that arrives is passed unmodified
	wire       drop_user = (USER_MODE == gbc_pkg::GBC_USER_DROP);
	wire       cur_drop  = in_sop ? (hdr_user && drop_user) : drop_beat;

	always_comb begin
		video_beat = 1'b0;
		drop_beat  = 1'b0;
		case (state)
			gbc_pkg::GBC_ST_VIDEO: video_beat = !in_sop;
			gbc_pkg::GBC_ST_DROP:  drop_beat  = !in_sop;
			default: ;
		endcase
	end

	always_comb begin
		next_state = state;
		if (in_take) begin
			if (in_sop && !in_eop) begin
				if (hdr_video) begin
					next_state = gbc_pkg::GBC_ST_VIDEO;
				end else if (hdr_ctrl) begin
					next_state = gbc_pkg::GBC_ST_CTRL;
				end else if (drop_user) begin
					next_state = gbc_pkg::GBC_ST_DROP;
				end else begin
					next_state = gbc_pkg::GBC_ST_PASS;
				end
			end else if (in_eop) begin
				next_state = gbc_pkg::GBC_ST_IDLE;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= gbc_pkg::GBC_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Sequential planes: one plane per beat, restarted by each header
	always_ff @(posedge mclk) begin
		if (srst) begin
			plane_cnt <= 2'h0;
		end else if (in_take && in_sop) begin
			plane_cnt <= 2'h0;
		end else if (in_take && video_beat) begin
			plane_cnt <= (plane_cnt == LAST_PLANE) ? 2'h0 : 2'(plane_cnt + 2'h1);
		end
	end

	// New packets are held off while the run bit is clear
	wire next_stop = (next_state == gbc_pkg::GBC_ST_IDLE) && !next_go;

	// ==========================================================
	// Sample datapath
	logic [DW-1:0] clamp_data;

	for (genvar i = 0; i < LANES; i++) begin : g_lane
		wire [1:0]     pl = PARALLEL ? 2'(i % PLANES) : plane_cnt;
		wire [BPS-1:0] s  = in_data[i*BPS +: BPS];
		// Flipping the top bit adds or removes half the range modulo the width
		wire [BPS-1:0] u  = SIGNED_IN ? {~s[BPS-1], s[BPS-2:0]} : s;
		wire [BPS-1:0] hi = hi_lim[pl];
		wire [BPS-1:0] lo = lo_lim[pl];
		// Unsigned compare on both sides
		wire [BPS-1:0] c  = (u > hi) ? hi :
		                    (u < lo) ? lo : u;
		assign clamp_data[i*BPS +: BPS] = SIGNED_OUT ? {~c[BPS-1], c[BPS-2:0]} : c;
	end

	wire [DW-1:0] beat_data = video_beat ? clamp_data : in_data;
	wire [DW+1:0] beat      = {in_sop, in_eop, beat_data};

	// ==========================================================
	// Output buffering
	wire          s1_valid;
	wire          s1_ready;
	wire [DW+1:0] s1_data;
	wire [DW+1:0] tail_data;

	gbc_skid #(
		.W(DW + 2)
	) u_stage1 (
		.clk     (mclk),
		.rst     (srst),
		.i_valid (in_valid && !cur_drop),
		.i_stop  (next_stop),
		.i_ready (in_ready),
		.i_data  (beat),
		.o_valid (s1_valid),
		.o_ready (s1_ready),
		.o_data  (s1_data)
	);

	if (EXTRA_PIPE) begin : g_pipe
		gbc_skid #(
			.W(DW + 2)
		) u_stage2 (
			.clk     (mclk),
			.rst     (srst),
			.i_valid (s1_valid),
			.i_stop  (1'b0),
			.i_ready (s1_ready),
			.i_data  (s1_data),
			.o_valid (out_valid),
			.o_ready (out_ready),
			.o_data  (tail_data)
		);
	end else begin : g_nopipe
		assign s1_ready  = out_ready;
		assign out_valid = s1_valid;
		assign tail_data = s1_data;
	end

	assign out_sop  = tail_data[DW+1];
	assign out_eop  = tail_data[DW];
	assign out_data = tail_data[DW-1:0];
endmodule

// *** design/gbc_pkg.sv ***
// Shared constants and types for the guard band clamp.
package gbc_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam int         GBC_ADDR_LSB     = 2;
	localparam int         GBC_IDX_W        = 4;
	localparam logic [3:0] GBC_IDX_CTRL     = 4'h0;
	localparam logic [3:0] GBC_IDX_STATUS   = 4'h1;
	localparam logic [3:0] GBC_IDX_INTR     = 4'h2;
	localparam logic [3:0] GBC_IDX_LIM_BASE = 4'h3;
	localparam logic [3:0] GBC_IDX_LAST     = 4'ha;

	// ==========================================================
	// Field positions
	localparam int GBC_GO_BIT   = 0;
	localparam int GBC_STAT_BIT = 0;

	// ==========================================================
	// Limits
	localparam int GBC_MAX_PLANES = 4;
	localparam int GBC_LIM_W      = 16;

	// ==========================================================
	// Packet types, carried in the low bits of the first beat
	localparam int         GBC_TYPE_W     = 4;
	localparam logic [3:0] GBC_TYPE_VIDEO = 4'h0;
	localparam logic [3:0] GBC_TYPE_CTRL  = 4'hf;

	// ==========================================================
	// Handling of user packets
	localparam int GBC_USER_NONE = 0;
	localparam int GBC_USER_DROP = 1;
	localparam int GBC_USER_PASS = 2;

	// ==========================================================
	// Packet state
	typedef enum logic [2:0] {
		GBC_ST_IDLE,
		GBC_ST_VIDEO,
		GBC_ST_CTRL,
		GBC_ST_PASS,
		GBC_ST_DROP
	} gbc_state_t;

endpackage

// *** bench/gbc_sink.sv ***
// Downstream video sink model that records every beat it accepts.
module gbc_sink (
	input  wire logic        mclk,
	input  wire logic        stall,
	input  wire logic        out_valid,
	input  wire logic [15:0] out_data,
	input  wire logic        out_sop,
	input  wire logic        out_eop,
	output logic             out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [17:0] q[$];
	logic [1:0]  ph = 2'h0;
	// One stall in four forces the block to hold a pending beat
	assign out_ready = !(stall && ph == 2'h3);
	always @(posedge mclk) begin
		ph <= ph + 2'h1;
		if (out_valid && out_ready)
			q.push_back({out_sop, out_eop, out_data});
	end
endmodule

// *** bench/gbc_chk_chk.sv ***
// Port checker for the guard band clamp.
module gbc_chk (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        in_valid,
	input wire logic        in_ready,
	input wire logic [15:0] in_data,
	input wire logic        in_sop,
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic [15:0] out_data,
	input wire logic        out_sop,
	input wire logic        out_eop
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// ==========================================================
	// Control slave
	ready_wait_a: assert property ($rose(psel && penable) |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready too long");
	idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata outside answer");
	bad_align_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned not refused");
	// ==========================================================
	// Stream
	beat_hold_a: assert property (out_valid && !out_ready |=>
		out_valid && $stable(out_data) && $stable({out_sop, out_eop}))
		else $error("beat dropped while stalled");
	take_out_a: assert property (in_valid && in_ready |=> out_valid)
		else $error("beat not forwarded");
	head_pass_a: assert property (in_valid && in_ready && in_sop && !out_valid |=>
		out_sop && out_data == $past(in_data))
		else $error("header modified");
	rst_quiet_a: assert property (disable iff (1'b0)
		srst |=> !out_valid && !in_ready && !pready)
		else $error("outputs active after reset");
	cover property (in_valid && in_ready && in_sop);
	cover property (pready && pslverr);
	cover property (out_valid && !out_ready);
endmodule

bind gbc_guard_band_clamp gbc_chk i_chk (.mclk(mclk), .srst(srst), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
	.in_sop(in_sop), .out_valid(out_valid), .out_ready(out_ready),
	.out_data(out_data), .out_sop(out_sop), .out_eop(out_eop));

// *** bench/tb.sv ***
// Self-checking bench for the guard band clamp.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, srst, psel, penable, pwrite, pready, pslverr, er, stall;
	logic        in_valid, in_ready, in_sop, in_eop, out_valid, out_ready, out_sop, out_eop;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] in_data, out_data;
	logic [17:0] eq[$];
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;

	gbc_guard_band_clamp i_dut (.mclk(mclk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
		.in_ready(in_ready), .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.out_sop(out_sop), .out_eop(out_eop));
	gbc_sink i_snk (.mclk(mclk), .stall(stall), .out_valid(out_valid),
		.out_data(out_data), .out_sop(out_sop), .out_eop(out_eop),
		.out_ready(out_ready));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ==========================================================
	// Access tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// The answer is taken at the rising edge that samples pready high
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic x);
		apb(1'b0, a, 32'h0);
		chk("prdata", e, rd);
		chk("pslverr", {31'h0, x}, {31'h0, er});
	endtask
	task automatic pkt(input logic [15:0] w[$], input logic s, input logic e);
		foreach (w[i]) begin
			in_valid <= 1'b1;
			in_sop <= s && i == 0;
			in_eop <= e && i == w.size() - 1;
			in_data <= w[i];
			do @(posedge mclk); while (in_ready !== 1'b1);
		end
		in_valid <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic stop_test;
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			stop_test();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, in_valid, in_sop, in_eop, stall} = 7'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		in_data = 16'h0;
		srst = 1'b1;
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		chk("in_ready", 32'h0, {31'h0, in_ready});
		rchk(8'h00, 32'h0, 1'b0);
		rchk(8'h04, 32'h0, 1'b0);
		for (int i = 3; i <= 10; i++)
			rchk(8'(i * 4), (i % 2) ? 32'h0 : 32'hff, 1'b0);
		rchk(8'h2c, 32'h0, 1'b1);
		rchk(8'h0d, 32'h0, 1'b1);
		apb(1'b1, 8'h04, 32'h1);
		rchk(8'h04, 32'h0, 1'b0);
		apb(1'b1, 8'h0c, 32'habcd0010);
		apb(1'b1, 8'h10, 32'he0);
		apb(1'b1, 8'h14, 32'h40);
		apb(1'b1, 8'h18, 32'h80);
		rchk(8'h0c, 32'h10, 1'b0);
		rchk(8'h18, 32'h80, 1'b0);
		apb(1'b1, 8'h00, 32'h1);
		stall <= 1'b1;
		// Video and control packets only, the stream is user packet free
		pkt('{16'h0000, 16'h0505, 16'hffff, 16'h8010, 16'h6020}, 1'b1, 1'b1);
		pkt('{16'h000f, 16'hffff}, 1'b1, 1'b1);
		pkt('{16'h0000}, 1'b1, 1'b0);
		rchk(8'h04, 32'h1, 1'b0);
		apb(1'b1, 8'h00, 32'h0);
		pkt('{16'h0102}, 1'b0, 1'b1);
		repeat (20) @(posedge mclk);
		chk("in_ready", 32'h0, {31'h0, in_ready});
		rchk(8'h04, 32'h0, 1'b0);
		eq = {18'h20000, 18'h04010, 18'h080e0, 18'h08010, 18'h16020,
			18'h2000f, 18'h1ffff, 18'h20000, 18'h14010};
		chk("beats", 32'(eq.size()), 32'(i_snk.q.size()));
		foreach (eq[i])
			chk("beat", 32'(eq[i]), 32'(i_snk.q[i]));
		stop_test();
	end
endmodule
